// ---- ccor_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ccor_map.svh"
module ccor_top
    import ccor_pkg::*;
#(
    parameter logic [1:0] PORT_TYPE   = `CCOR_PORT_DRP,
    parameter int         DRP_CYCLES  = `CCOR_DRP_CYCLES,
    parameter int         DEB_CYCLES  = `CCOR_STABLE_CYCLES,
    parameter bit         DUAL_LANE   = 1'b0
) (
    input  wire logic        ref_clk,      // 40 mhz clock
    input  wire logic        rst,          // async reset, high
    input  wire ccor_cc_type cc_sense,     // comparator result per cc pin
    input  wire logic        vbus_present, // sink: vbus seen
    input  wire logic        role_force,   // manual role select enable
    input  wire logic        role_src,     // manual role: 1 source
    input  wire logic        cable_done,   // optional cable query finished
    output logic             rp_en_r,      // present pull-up on both cc
    output logic             rd_en_r,      // present pull-down on both cc
    output logic             vbus_en_r,    // apply vbus
    output logic             vconn1_en_r,  // vconn onto cc1
    output logic             vconn2_en_r,  // vconn onto cc2
    output ccor_route_type   route_r,      // lane routing select
    output logic             attached_r,   // connection live
    output logic             is_src_r,     // attached as source
    output logic             cable_q_r,    // cable query window open
    output logic             pwr_neg_r     // power negotiation allowed
);
    // ****************************************************************
    // state
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_UNATT_SRC = 3'b000,
        ST_UNATT_SNK = 3'b001,
        ST_ATT_SRC   = 3'b010,
        ST_ATT_SNK   = 3'b011,
        ST_CABLE     = 3'b100,
        ST_POWER     = 3'b101
    } ccor_state_type;

    ccor_state_type state_r, state_nxt;
    logic [31:0]    tgl_r;
    logic           flip_r, flip_nxt;

    // ****************************************************************
    // pin conditioning
    // ****************************************************************
    // comparator outputs are asynchronous to ref_clk, so synchronise first
    logic [3:0] cc_sync, cc_stab;
    ccor_sync #(.WIDTH(4)) u_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .din     (cc_sense),
        .dout    (cc_sync)
    );
    ccor_debounce #(.WIDTH(4), .CYCLES(DEB_CYCLES)) u_deb (
        .ref_clk (ref_clk),
        .rst     (rst),
        .din     (cc_sync),
        .dout    (cc_stab)
    );
    logic [1:0] vbus_s;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst)
            vbus_s <= 2'b00;
        else
            vbus_s <= {vbus_s[0], vbus_present};
    end

    // ****************************************************************
    // decode
    // ****************************************************************
    function automatic logic is_term(input logic [1:0] t,
                                     input ccor_term_type k);
        return t == k;
    endfunction

    wire [1:0] cc1 = cc_stab[3:2];
    wire [1:0] cc2 = cc_stab[1:0];
    // exactly one pull-down: sink found; rd/rd and ra/ra are accessories
    wire rd1 = is_term(cc1, CCOR_TERM_RD);
    wire rd2 = is_term(cc2, CCOR_TERM_RD);
    wire ra1 = is_term(cc1, CCOR_TERM_RA);
    wire ra2 = is_term(cc2, CCOR_TERM_RA);
    wire snk_seen = rd1 ^ rd2;
    // pulled-up pin marks orientation on the sink side
    wire rp1 = is_term(cc1, CCOR_TERM_RP);
    wire rp2 = is_term(cc2, CCOR_TERM_RP);
    wire src_seen = (rp1 ^ rp2) && vbus_s[1];
    wire can_src = (PORT_TYPE != `CCOR_PORT_SNK);
    wire can_snk = (PORT_TYPE != `CCOR_PORT_SRC);
    wire is_drp  = (PORT_TYPE == `CCOR_PORT_DRP);
    wire want_src = role_force ? role_src : 1'b1;
    wire tgl_done = (tgl_r == 32'(DRP_CYCLES - 1));
    // only allow toggling when not forced to one role
    wire do_tgl = is_drp && !role_force && tgl_done;

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        state_nxt = state_r;
        flip_nxt  = flip_r;
        case (state_r)
            ST_UNATT_SRC: begin
                if (!can_src || !want_src) begin
                    state_nxt = ST_UNATT_SNK;
                end else if (snk_seen) begin
                    state_nxt = ST_ATT_SRC;
                    flip_nxt  = rd2;
                end else if (do_tgl) begin
                    state_nxt = ST_UNATT_SNK;
                end
            end
            ST_UNATT_SNK: begin
                if (!can_snk || (role_force && role_src)) begin
                    state_nxt = ST_UNATT_SRC;
                end else if (src_seen) begin
                    state_nxt = ST_ATT_SNK;
                    flip_nxt  = rp2;
                end else if (do_tgl) begin
                    state_nxt = ST_UNATT_SRC;
                end
            end
            ST_ATT_SRC, ST_ATT_SNK: begin
                state_nxt = ST_CABLE;
            end
            ST_CABLE: begin
                if (cable_done)
                    state_nxt = ST_POWER;
            end
            ST_POWER: begin
                state_nxt = ST_POWER;
            end
            default: begin
                state_nxt = ST_UNATT_SRC;
            end
        endcase
        // detach overrides every attached state
        if (attached_r) begin
            if (is_src_r && !(flip_r ? rd2 : rd1))
                state_nxt = ST_UNATT_SRC;
            if (!is_src_r && !((flip_r ? rp2 : rp1) && vbus_s[1]))
                state_nxt = ST_UNATT_SNK;
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    wire att_nxt = (state_nxt == ST_ATT_SRC) || (state_nxt == ST_ATT_SNK) ||
                   (state_nxt == ST_CABLE)   || (state_nxt == ST_POWER);
    wire entering_src = att_nxt && !attached_r && (state_nxt == ST_ATT_SRC);
    wire src_nxt = attached_r ? is_src_r : entering_src;
    // flip only moves at attach; held through the whole connection
    wire flip_hold = attached_r ? flip_r : flip_nxt;
    wire ra_other = flip_hold ? ra1 : ra2;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst)
            tgl_r <= 32'h0000_0000;
        else if (tgl_done || attached_r || state_nxt != state_r)
            tgl_r <= 32'h0000_0000;
        else
            tgl_r <= tgl_r + 32'h0000_0001;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_r <= ST_UNATT_SRC;
            flip_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            flip_r  <= flip_hold;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rp_en_r     <= 1'b0;
            rd_en_r     <= 1'b0;
            vbus_en_r   <= 1'b0;
            vconn1_en_r <= 1'b0;
            vconn2_en_r <= 1'b0;
            route_r     <= '0;
            attached_r  <= 1'b0;
            is_src_r    <= 1'b0;
            cable_q_r   <= 1'b0;
            pwr_neg_r   <= 1'b0;
        end else begin
            rp_en_r     <= (state_nxt == ST_UNATT_SRC) || (att_nxt && src_nxt);
            rd_en_r     <= (state_nxt == ST_UNATT_SNK) ||
                           (att_nxt && !src_nxt);
            // power only to a detected sink; never in a dead pairing
            vbus_en_r   <= att_nxt && src_nxt;
            vconn1_en_r <= att_nxt && src_nxt && flip_hold && ra_other;
            vconn2_en_r <= att_nxt && src_nxt && !flip_hold && ra_other;
            route_r.valid     <= att_nxt;
            route_r.flip      <= att_nxt && flip_hold;
            // lane 0 follows the active cc pair set
            route_r.lane0_sel <= att_nxt && flip_hold;
            route_r.lane1_sel <= att_nxt && DUAL_LANE && !flip_hold;
            attached_r  <= att_nxt;
            is_src_r    <= att_nxt && src_nxt;
            cable_q_r   <= (state_nxt == ST_CABLE);
            pwr_neg_r   <= (state_nxt == ST_POWER);
        end
    end
endmodule
`default_nettype wire

// ---- ccor_map.svh ----
// Contract
// - each port uses CC1 and CC2 for attach, orientation, roles and supply.
// - hub upstream and downstream links resolve as independent connections.
// - single-lane port contains a switch routing tx/rx to the wired pair set.
// - source selects pair set from which cc pin the far end terminates.
// - sink drives its switch select from which cc pin the host terminates.
// - dual-lane: pair set aligned with active cc is lane 0, other lane 1.
// - four cable states handled: flipped or not, straight or twisted.
// - fixed-plug far device leaves only two connection states to resolve.
// - source-source or sink-sink pairing: never apply vbus or vconn.
// - pairings with a dual-role port become functional, auto or manual.
// - detect connection first, then optional cable query, then power.
// - power negotiation may use pd messaging, current modes or bc 1.2.
// - source finds orientation from the cc pin sensing the pull-down.
// - powered sink finds orientation from the cc pin pulled up.
// - dual-role port alternates source and sink until a connection forms.
// - on pull-down loss source drops vbus and vconn and searches again.
`ifndef CCOR_MAP_SVH
`define CCOR_MAP_SVH
`define CCOR_CLK_HZ         40000000
`define CCOR_DRP_TOGGLE_US  50
`define CCOR_DRP_CYCLES     ((`CCOR_CLK_HZ / 1000000) * `CCOR_DRP_TOGGLE_US)
`define CCOR_STABLE_CYCLES  16
`define CCOR_PORT_SRC       2'h0
`define CCOR_PORT_SNK       2'h1
`define CCOR_PORT_DRP       2'h2
`endif

// ---- ccor_pkg.sv ----
package ccor_pkg;
    typedef enum logic [1:0] {
        CCOR_TERM_OPEN = 2'b00,
        CCOR_TERM_RA   = 2'b01,
        CCOR_TERM_RD   = 2'b10,
        CCOR_TERM_RP   = 2'b11
    } ccor_term_type;
    typedef struct packed {
        ccor_term_type cc1;
        ccor_term_type cc2;
    } ccor_cc_type;
    typedef struct packed {
        logic flip;
        logic lane0_sel;
        logic lane1_sel;
        logic valid;
    } ccor_route_type;
endpackage

// ---- ccor_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module ccor_sync #(
    parameter int WIDTH = 4
) (
    input  wire logic             ref_clk, // clock
    input  wire logic             rst,     // async reset
    input  wire logic [WIDTH-1:0] din,     // pin level
    output var  logic [WIDTH-1:0] dout     // synchronised level
);
    logic [WIDTH-1:0] meta_r;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            meta_r <= '0;
            dout   <= '0;
        end else begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end
endmodule
`default_nettype wire

// ---- ccor_debounce.sv ----
`timescale 1ns/1ps
`default_nettype none
module ccor_debounce #(
    parameter int WIDTH  = 4,
    parameter int CYCLES = 16
) (
    input  wire logic             ref_clk, // clock
    input  wire logic             rst,     // async reset
    input  wire logic [WIDTH-1:0] din,     // synchronised input
    output var  logic [WIDTH-1:0] dout     // stable value
);
    logic [WIDTH-1:0] last_r;
    logic [15:0]      cnt_r;
    wire              same = (din == last_r);
    wire              done = (cnt_r == 16'(CYCLES - 1));
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            last_r <= '0;
            cnt_r  <= 16'h0000;
            dout   <= '0;
        end else begin
            last_r <= din;
            if (!same)
                cnt_r <= 16'h0000;
            else if (!done)
                cnt_r <= cnt_r + 16'h0001;
            if (same && done)
                dout <= din;
        end
    end
endmodule
`default_nettype wire

// ---- ccor_top_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module ccor_top_asserts
    import ccor_pkg::*;
(
    input wire logic           ref_clk,      // clock
    input wire logic           rst,          // async reset
    input wire ccor_cc_type    cc_sense,     // cc terminations
    input wire logic           cable_done,   // cable query done
    input wire logic           rp_en_r,      // pull-ups shown
    input wire logic           rd_en_r,      // pull-downs shown
    input wire logic           vbus_en_r,    // vbus applied
    input wire logic           vconn1_en_r,  // vconn on cc1
    input wire logic           vconn2_en_r,  // vconn on cc2
    input wire ccor_route_type route_r,      // lane routing
    input wire logic           attached_r,   // connection live
    input wire logic           is_src_r,     // attached as source
    input wire logic           cable_q_r,    // cable query window
    input wire logic           pwr_neg_r     // power step allowed
);
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_vbus_src_only: assert property (vbus_en_r |-> attached_r && is_src_r)
        else $error("vbus applied without source attach");
    a_detach_drops: assert property ($fell(attached_r) |->
        !vbus_en_r && !vconn1_en_r && !vconn2_en_r)
        else $error("power left on after detach");
    a_route_held: assert property (attached_r && $past(attached_r)
        |-> $stable(route_r)) else $error("routing moved while attached");
    a_valid_tracks: assert property (route_r.valid == attached_r)
        else $error("route valid differs from attach");
    a_src_orient: assert property ($rose(attached_r) && is_src_r
        |-> route_r.flip == (cc_sense.cc2 == CCOR_TERM_RD))
        else $error("source orientation wrong");
    a_snk_orient: assert property ($rose(attached_r) && !is_src_r
        |-> route_r.flip == (cc_sense.cc2 == CCOR_TERM_RP))
        else $error("sink orientation wrong");
    a_vconn_side: assert property ((vconn1_en_r || vconn2_en_r)
        |-> is_src_r && vconn1_en_r == route_r.flip
        && vconn2_en_r == !route_r.flip) else $error("vconn on wrong pin");
    a_role_excl: assert property (!(rp_en_r && rd_en_r))
        else $error("pull-up and pull-down together");
    a_attach_cable: assert property ($rose(attached_r) |=> cable_q_r)
        else $error("cable window did not open");
    a_cable_order: assert property (cable_q_r |-> attached_r && !pwr_neg_r)
        else $error("cable window out of order");
    a_power_order: assert property ($rose(pwr_neg_r)
        |-> $past(cable_q_r) && $past(cable_done))
        else $error("power step before cable step");
endmodule
`default_nettype wire

// ---- ccor_partner.sv ----
`timescale 1ns/1ps
`default_nettype none
module ccor_partner
    import ccor_pkg::*;
(
    input  wire logic [1:0]  mode,         // 0 none 1 sink 2 source 3 rd/rd
    input  wire logic        flip,         // plug turned over
    input  wire logic        ra,           // powered cable ra on other pin
    input  wire logic        rp_en_r,      // near end shows pull-up
    input  wire logic        rd_en_r,      // near end shows pull-down
    output var  ccor_cc_type cc_sense,     // terminations seen by near end
    output var  logic        vbus_present  // far source drives vbus
);
    // ****************************************
    // far port termination
    // ****************************************
    ccor_term_type act;
    ccor_term_type oth;
    // a sink's rd is only sensed while the near end pulls up
    assign act = (mode == 2'h1 && rp_en_r) ? CCOR_TERM_RD :
                 (mode == 2'h2 && rd_en_r) ? CCOR_TERM_RP :
                 (mode == 2'h3 && rp_en_r) ? CCOR_TERM_RD : CCOR_TERM_OPEN;
    assign oth = (mode == 2'h3 && rp_en_r) ? CCOR_TERM_RD :
                 (ra && mode == 2'h1) ? CCOR_TERM_RA : CCOR_TERM_OPEN;
    assign cc_sense = flip ? '{cc1: oth, cc2: act} : '{cc1: act, cc2: oth};
    assign vbus_present = (mode == 2'h2) && rd_en_r;
endmodule
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import ccor_pkg::*;
;
    logic ref_clk = 1'b0, rst = 1'b1, flip = 1'b0, ra = 1'b0;
    logic cable_done = 1'b0, vbus_present, rp_en_r, rd_en_r, vbus_en_r;
    logic vconn1_en_r, vconn2_en_r, attached_r, is_src_r, cable_q_r, pwr_neg_r;
    logic [1:0] mode = 2'h0;
    logic role_force = 1'b0, role_src = 1'b0;
    ccor_cc_type cc_sense;
    ccor_route_type route_r;
    int fails = 0, checks_done = 0;
    // ****************************************
    // harness
    // ****************************************
    initial forever #12.5 ref_clk = ~ref_clk;
    ccor_partner FAR (.mode(mode), .flip(flip), .ra(ra), .rp_en_r(rp_en_r),
        .rd_en_r(rd_en_r), .cc_sense(cc_sense), .vbus_present(vbus_present));
    // short counts keep drp toggling and debounce quick in simulation
    ccor_top #(.DRP_CYCLES(8), .DEB_CYCLES(2)) DUT (.ref_clk(ref_clk),
        .rst(rst), .cc_sense(cc_sense), .vbus_present(vbus_present),
        .role_force(role_force), .role_src(role_src), .cable_done(cable_done),
        .rp_en_r(rp_en_r), .rd_en_r(rd_en_r), .vbus_en_r(vbus_en_r),
        .vconn1_en_r(vconn1_en_r), .vconn2_en_r(vconn2_en_r),
        .route_r(route_r), .attached_r(attached_r), .is_src_r(is_src_r),
        .cable_q_r(cable_q_r), .pwr_neg_r(pwr_neg_r));
    task automatic check(input string nm, input logic s, input logic e);
        checks_done++;
        if (s !== e) begin
            fails++;
            $display("mismatch %s expected %b seen %b", nm, e, s);
        end
    endtask
    task automatic summarize();
        if (fails == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic wait_att(input logic lvl);
        for (int i = 0; i < 200 && attached_r !== lvl; i++) @(negedge ref_clk);
        check("attached", attached_r, lvl);
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_src(input logic f, input logic r);
        @(posedge ref_clk);
        mode <= 2'h1;
        flip <= f;
        ra <= r;
        wait_att(1'b1);
        check("is_src", is_src_r, 1'b1);
        check("flip", route_r.flip, f);
        check("valid", route_r.valid, 1'b1);
        check("lane0", route_r.lane0_sel, f);
        check("lane1", route_r.lane1_sel, 1'b0);
        check("vbus", vbus_en_r, 1'b1);
        check("vconn1", vconn1_en_r, r && f);
        check("vconn2", vconn2_en_r, r && !f);
        @(negedge ref_clk);
        check("cable_q", cable_q_r, 1'b1);
        check("pwr_early", pwr_neg_r, 1'b0);
        @(posedge ref_clk);
        cable_done <= 1'b1;
        @(posedge ref_clk);
        cable_done <= 1'b0;
        @(negedge ref_clk);
        check("pwr_neg", pwr_neg_r, 1'b1);
        check("cable_end", cable_q_r, 1'b0);
        @(posedge ref_clk);
        mode <= 2'h0;
        wait_att(1'b0);
        check("vbus_off", vbus_en_r, 1'b0);
        check("vconn_off", vconn1_en_r | vconn2_en_r, 1'b0);
        check("route_clr", route_r.valid, 1'b0);
    endtask
    task automatic t_snk(input logic f);
        @(posedge ref_clk);
        mode <= 2'h2;
        flip <= f;
        ra <= 1'b0;
        wait_att(1'b1);
        check("snk_role", is_src_r, 1'b0);
        check("snk_flip", route_r.flip, f);
        check("snk_vbus", vbus_en_r, 1'b0);
        @(posedge ref_clk);
        mode <= 2'h0;
        wait_att(1'b0);
    endtask
    task automatic t_refuse();
        logic sp;
        logic sd;
        sp = 1'b0;
        sd = 1'b0;
        @(posedge ref_clk);
        mode <= 2'h3;
        repeat (100) begin
            @(negedge ref_clk);
            sp |= rp_en_r;
            sd |= rd_en_r;
        end
        check("rdrd_att", attached_r, 1'b0);
        check("rdrd_vbus", vbus_en_r, 1'b0);
        check("toggle_rp", sp, 1'b1);
        check("toggle_rd", sd, 1'b1);
        @(posedge ref_clk);
        mode <= 2'h0;
    endtask
    // forced role against a far port of the same role: no function
    task automatic t_role(input logic s);
        @(posedge ref_clk);
        role_force <= 1'b1;
        role_src <= s;
        mode <= s ? 2'h2 : 2'h1;
        repeat (60) @(negedge ref_clk);
        check("same_att", attached_r, 1'b0);
        check("same_vbus", vbus_en_r, 1'b0);
        check("forced_rp", rp_en_r, s);
        check("forced_rd", rd_en_r, !s);
        @(posedge ref_clk);
        role_force <= 1'b0;
        mode <= 2'h0;
    endtask
    initial begin
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        t_src(1'b0, 1'b0);
        t_src(1'b1, 1'b1);
        t_src(1'b0, 1'b1);
        t_snk(1'b0);
        t_snk(1'b1);
        t_refuse();
        t_role(1'b1);
        t_role(1'b0);
        summarize();
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        summarize();
    end
endmodule
bind ccor_top ccor_top_asserts CHK (.ref_clk(ref_clk), .rst(rst),
    .cc_sense(cc_sense), .cable_done(cable_done), .rp_en_r(rp_en_r),
    .rd_en_r(rd_en_r), .vbus_en_r(vbus_en_r), .vconn1_en_r(vconn1_en_r),
    .vconn2_en_r(vconn2_en_r), .route_r(route_r), .attached_r(attached_r),
    .is_src_r(is_src_r), .cable_q_r(cable_q_r), .pwr_neg_r(pwr_neg_r));
`default_nettype wire
